// file: src/lbam_pkg.sv
// Package for the leaky-bucket activity monitor: register map, reset values, timing.
// Assumes a 100 MHz clock and an 8-bit register port.
package lbam_pkg;
  localparam logic [7:0] ADDR_UPPER_THRESH = 8'h58;
  localparam logic [7:0] ADDR_LOWER_THRESH = 8'h59;
  localparam logic [7:0] ADDR_BUCKET_CEIL  = 8'h5A;
  localparam logic [7:0] ADDR_LEAK_RATE    = 8'h5B;
  localparam logic [7:0] ADDR_LEVEL        = 8'h5C;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h5D;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h5E;
  localparam logic [7:0] RST_UPPER_THRESH  = 8'h06;
  localparam logic [7:0] RST_LOWER_THRESH  = 8'h04;
  localparam logic [7:0] RST_BUCKET_CEIL   = 8'h08;
  localparam logic [7:0] RST_LEAK_RATE     = 8'h01;
  localparam int         LEAK_RATE_W       = 2;
  localparam int         IRQ_RAISE_BIT     = 0;
  localparam int         IRQ_CLEAR_BIT     = 1;
  localparam int         IRQ_W             = 2;
  localparam int         CLK_HZ            = 100_000_000;
  localparam int         EVAL_PERIOD_MS    = 128;
  localparam int         EVAL_CYCLES       = CLK_HZ / 1000 * EVAL_PERIOD_MS;
endpackage : lbam_pkg

// file: src/lbam_tick.sv
// Free-running divider producing one pulse per evaluation period.
// Assumes a single clock domain with a common clock enable.
`timescale 1ns/1ps
`default_nettype none
module lbam_tick #(
  parameter int PERIOD = lbam_pkg::EVAL_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  output var  logic tick
);
  // A period of one clock would leave the divider with no count to run.
  if (PERIOD < 2) begin : g_bad_period
    $error("PERIOD must be at least 2");
  end
  localparam int CW = $clog2(PERIOD);
  logic [CW-1:0] count;
  wire           at_end = (count == CW'(PERIOD - 1));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (clk_en) begin
      count <= at_end ? '0 : count + 1'b1;
      tick  <= at_end;
    end
  end
endmodule : lbam_tick
`default_nettype wire

// file: src/lbam_top.sv
// Leaky-bucket input activity monitor with register port and interrupt.
// Assumes fault_in comes from another domain and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RL1 - Update bucket once per 128 ms period.
// RL2 - Faulty period adds one to bucket.
// RL3 - Clean stretch of 1/2/4/8 periods subtracts one.
// RL4 - Bucket never exceeds programmed ceiling; a ceiling lowered below the level clamps it only at the next tick.
// RL5 - Leak rate field selects clean stretch length.
// RL6 - Raise alarm when bucket reaches upper threshold.
// RL7 - Clear alarm when bucket falls to lower.
// RL8 - Empty bucket stays at zero on decrement.
module lbam_top #(
  parameter int EVAL_CYCLES = lbam_pkg::EVAL_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       fault_in,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output var  logic [7:0] rdata,
  output var  logic       alarm,
  output var  logic       irq
);
  logic       fault_s1;
  logic       fault_s2;
  logic       fault_seen;
  logic       tick;
  logic [7:0] upper_thresh;
  logic [7:0] lower_thresh;
  logic [7:0] bucket_ceiling;
  logic [1:0] leak_rate_select;
  logic [7:0] level;
  logic [2:0] clean_count;
  logic [lbam_pkg::IRQ_W-1:0] irq_status;
  logic [lbam_pkg::IRQ_W-1:0] irq_mask;

  lbam_tick #(.PERIOD(EVAL_CYCLES)) u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .tick    (tick)
  );

  // Register decode.
  wire wr_upper = wr_en && (addr == lbam_pkg::ADDR_UPPER_THRESH);
  wire wr_lower = wr_en && (addr == lbam_pkg::ADDR_LOWER_THRESH);
  wire wr_ceil  = wr_en && (addr == lbam_pkg::ADDR_BUCKET_CEIL);
  wire wr_rate  = wr_en && (addr == lbam_pkg::ADDR_LEAK_RATE);
  wire wr_stat  = wr_en && (addr == lbam_pkg::ADDR_IRQ_STATUS);
  wire wr_mask  = wr_en && (addr == lbam_pkg::ADDR_IRQ_MASK);

  wire [7:0] read_mux =
    (addr == lbam_pkg::ADDR_UPPER_THRESH) ? upper_thresh :
    (addr == lbam_pkg::ADDR_LOWER_THRESH) ? lower_thresh :
    (addr == lbam_pkg::ADDR_BUCKET_CEIL)  ? bucket_ceiling :
    (addr == lbam_pkg::ADDR_LEAK_RATE)    ? {6'h00, leak_rate_select} :
    (addr == lbam_pkg::ADDR_LEVEL)        ? level :
    (addr == lbam_pkg::ADDR_IRQ_STATUS)   ? {6'h00, irq_status} :
    (addr == lbam_pkg::ADDR_IRQ_MASK)     ? {6'h00, irq_mask} : 8'h00;

  // Clean stretch length in periods minus one: 0, 1, 3 or 7.
  wire [2:0] clean_last  = 3'((4'h1 << leak_rate_select) - 4'h1); // RL5
  wire       faulty      = fault_seen || fault_s2;
  wire       leak_due    = !faulty && (clean_count == clean_last); // RL3
  wire       can_fill    = level < bucket_ceiling;
  // A ceiling lowered below the current level pulls the level down to it.
  wire [7:0] next_level  =
    (level > bucket_ceiling)      ? bucket_ceiling :
    (faulty && can_fill)          ? level + 8'h01 : // RL2 RL4
    (leak_due && level != 8'h00)  ? level - 8'h01 : // RL3 RL8
    level;
  wire [2:0] next_clean  = (faulty || leak_due) ? 3'h0 : clean_count + 3'h1;
  wire       rise_now    = !alarm && (next_level >= upper_thresh); // RL6
  wire       fall_now    = alarm && (next_level <= lower_thresh); // RL7
  wire [lbam_pkg::IRQ_W-1:0] irq_events = {fall_now, rise_now};
  wire       ev_ok       = tick && clk_en;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_s1 <= 1'b0;
      fault_s2 <= 1'b0;
    end else if (clk_en) begin
      fault_s1 <= fault_in;
      fault_s2 <= fault_s1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upper_thresh     <= lbam_pkg::RST_UPPER_THRESH;
      lower_thresh     <= lbam_pkg::RST_LOWER_THRESH;
      bucket_ceiling   <= lbam_pkg::RST_BUCKET_CEIL;
      leak_rate_select <= lbam_pkg::RST_LEAK_RATE[1:0];
      irq_mask         <= '0;
      rdata            <= 8'h00;
    end else if (clk_en) begin
      if (wr_upper) upper_thresh <= wdata;
      if (wr_lower) lower_thresh <= wdata;
      if (wr_ceil)  bucket_ceiling <= wdata;
      if (wr_rate)  leak_rate_select <= wdata[1:0];
      if (wr_mask)  irq_mask <= wdata[lbam_pkg::IRQ_W-1:0];
      rdata <= rd_en ? read_mux : 8'h00;
    end
  end

  // Faults anywhere within a period are remembered until the period closes.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_seen  <= 1'b0;
      level       <= 8'h00;
      clean_count <= 3'h0;
      alarm       <= 1'b0;
    end else if (clk_en) begin
      if (tick) begin // RL1
        fault_seen  <= 1'b0;
        level       <= next_level;
        clean_count <= next_clean;
        if (rise_now) alarm <= 1'b1; // RL6
        else if (fall_now) alarm <= 1'b0; // RL7
      end else if (fault_s2) begin
        fault_seen <= 1'b1;
      end
    end
  end

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else if (clk_en) begin
      irq_status <= (irq_status & ~(wr_stat ? wdata[lbam_pkg::IRQ_W-1:0] : '0))
                    | (ev_ok ? irq_events : '0);
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule : lbam_top
`default_nettype wire

// file: dv/lbam_checker.sv
// Port checks for lbam_top: register readback and alarm timing.
// Assumes clk_en is held high.
`timescale 1ns/1ps
`default_nettype none
module lbam_checker (
  input wire logic       clk, reset_n, clk_en, fault_in, wr_en, rd_en, alarm, irq,
  input wire logic [7:0] addr, wdata, rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence wr_rd(logic [7:0] a);
    wr_en && addr == a ##1 rd_en && addr == a;
  endsequence
  chk_rd_idle: assert property (!$past(rd_en) |-> rdata == 8'h00) else $error("rdata not idle");
  chk_rd_unmapped: assert property (rd_en && addr == 8'h00 |=> rdata == 8'h00) else $error("unm");
  chk_ceil_back:
    assert property (wr_rd(8'h5A) |=> rdata == $past(wdata, 2)) else $error("ceil");
  chk_rate_back:
    assert property (wr_rd(8'h5B) |=> rdata == ($past(wdata, 2) & 8'h03)) else $error("rate");
  chk_lower_back:
    assert property (wr_rd(8'h59) |=> rdata == $past(wdata, 2)) else $error("lower");
  chk_stat_high: assert property (rd_en && addr == 8'h5D |=> rdata[7:2] == 6'h00) else $error("st");
  chk_mask_high: assert property (rd_en && addr == 8'h5E |=> rdata[7:2] == 6'h00) else $error("mk");
  // Once alarm moves it must stay put for the next eight clocks.
  chk_alarm_hold:
    assert property ($changed(alarm) |=> $stable(alarm) [*8]) else $error("alarm moved");
endmodule : lbam_checker
bind lbam_top lbam_checker chk_u (.clk, .reset_n, .clk_en, .fault_in, .wr_en, .rd_en,
  .alarm, .irq, .addr, .wdata, .rdata);
`default_nettype wire

// file: dv/lbam_fault_src.sv
// Stand-in for the input clock quality detector.
// Assumes the bench says when the monitored input is bad.
`timescale 1ns/1ps
`default_nettype none
module lbam_fault_src (
  input  wire logic clk,
  input  wire logic bad,
  output var  logic fault
);
  initial fault = 1'b0;
  // The detector has its own timing, so its flag moves away from our edges.
  always @(posedge clk) fault <= #3 bad;
endmodule : lbam_fault_src
`default_nettype wire

// file: dv/lbam_tb_top.sv
// Self-checking bench for lbam_top with a reference model.
// Assumes EVAL_CYCLES of 20, so each period task lasts 20 clocks.
`timescale 1ns/1ps
`default_nettype none
module lbam_tb_top;
  logic       clk = 0, reset_n = 0, bad = 0, fault, wr_en = 0, rd_en = 0, alarm, irq, alm = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, msk;
  logic [1:0] st = 2'b00;
  logic       en = 1'b1;
  int         miscompares = 0, cmp_count = 0, cyc = 0, lvl = 0, cln = 0, r = 1, ceil = 7;
  always #5 clk = ~clk;
  lbam_fault_src src_u (.clk(clk), .bad(bad), .fault(fault));
  lbam_top #(.EVAL_CYCLES(20)) dut_u (.clk(clk), .reset_n(reset_n), .clk_en(en),
    .fault_in(fault), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .alarm(alarm), .irq(irq));
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic wr(logic [7:0] a, logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
  endtask : wr
  task automatic rd(logic [7:0] a);
    addr <= a;
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd
  task automatic step(logic f);
    if (f) begin
      lvl = (lvl < ceil) ? lvl + 1 : ceil;
      cln = 0;
    end else if (++cln == (1 << r)) begin
      cln = 0;
      lvl = (lvl > 0) ? lvl - 1 : 0;
    end
    if (lvl >= 6 && !alm) begin
      alm = 1'b1;
      st[0] = 1'b1;
    end else if (lvl <= 2 && alm) begin
      alm = 1'b0;
      st[1] = 1'b1;
    end
  endtask : step
  // One evaluation period: the fault pulse sits well clear of the tick edge.
  task automatic period(logic f);
    wr(8'h5B, 8'hFC | 8'(r));
    rd(8'h5B);
    cmp("rate", 8'(r), d);
    wr(8'h5E, msk);
    wr_en <= 1'b0;
    bad <= f;
    repeat (7) @(posedge clk);
    bad <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h5C);
    cmp("level", 8'(lvl), d);
    cmp("alarm", {7'h00, alm}, {7'h00, alarm});
    rd(8'h5D);
    cmp("status", {6'h00, st}, d);
    cmp("irq", {7'h00, |(st & msk[1:0])}, {7'h00, irq});
    wr(8'h5D, 8'h03);
    st = 2'b00;
    step(f);
  endtask : period
  initial begin
    logic [7:0] ra [7] = '{8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5D, 8'h5E, 8'h00};
    logic [7:0] re [7] = '{8'h06, 8'h04, 8'h08, 8'h01, 8'h00, 8'h00, 8'h00};
    void'($urandom(32'hF2C8));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i]);
      cmp("reset value", re[i], d);
    end
    wr(8'h5A, 8'h07);
    rd(8'h5A);
    cmp("ceiling", 8'h07, d);
    wr(8'h59, 8'h02);
    rd(8'h59);
    cmp("lower", 8'h02, d);
    step(1'b0);
    for (r = 0; r < 4; r++) begin
      msk = (r == 3) ? 8'h00 : 8'h03;
      for (int i = 0; i < 16; i++)
        period(i < 3 || (i < 10 && $urandom % 4 != 0));
      $display("test rate %0d done", r);
    end
    // A read taken while the enable is low must leave the read port frozen at zero.
    en <= 1'b0;
    rd(8'h5A);
    cmp("frozen rdata", 8'h00, d);
    en <= 1'b1;
    $display("test freeze done");
    stop_test();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      stop_test();
    end
  end
endmodule : lbam_tb_top
`default_nettype wire
